// ---- logic/npi_pkg.sv ----
// Constants for the nested priority interrupt controller
package npi_pkg;

  // ==========================================================
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_SW_PRIO_0 = 8'h00;
  localparam logic [7:0] OFF_SW_PRIO_1 = 8'h04;
  localparam logic [7:0] OFF_SW_PRIO_2 = 8'h08;
  localparam logic [7:0] OFF_SW_PRIO_3 = 8'h0C;
  localparam logic [7:0] OFF_EXT_SENSE = 8'h10;
  localparam logic [7:0] OFF_COND_CODE = 8'h14;
  localparam logic [7:0] OFF_PENDING   = 8'h18;

  // ==========================================================
  // Reset values and fields
  localparam logic [7:0] SW_PRIO_RST   = 8'hFF;
  localparam logic [7:0] EXT_SENSE_RST = 8'h00;
  localparam logic [7:0] CC_RST        = 8'hEA;
  localparam logic [3:0] PRIO3_RO_BITS = 4'hF;
  localparam int         CC_HI_POS     = 5;
  localparam int         CC_LO_POS     = 3;
  localparam int         SENS_B_POS    = 6;
  localparam int         POL_B_POS     = 5;
  localparam int         SENS_A_POS    = 3;
  localparam int         POL_A_POS     = 2;
  localparam logic [7:0] EXT_SENSE_MASK = 8'hFC;

  // ==========================================================
  // Priority codes {hi, lo}
  localparam logic [1:0] CODE_LVL0 = 2'h2;
  localparam logic [1:0] CODE_LVL3 = 2'h3;

  // ==========================================================
  // Vectors
  localparam int          NUM_VEC       = 14;
  localparam int          VEC_CLK       = 1;
  localparam int          VEC_EXT_A     = 2;
  localparam int          VEC_EXT_F     = 3;
  localparam int          VEC_EXT_B_LOW = 4;
  localparam int          VEC_EXT_B_HI  = 5;
  localparam int          VEC_SPI       = 7;
  localparam logic [13:0] HALT_WAKE_MASK = 14'h003C;
  localparam logic [15:0] VEC_ADDR_TOP  = 16'hFFFA;
  localparam logic [15:0] VEC_ADDR_TRAP = 16'hFFFC;

  // ==========================================================
  // Sensitivity modes
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_BOTH     = 2'h3;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN         = 2'b00,
    MODE_WAIT        = 2'b01,
    MODE_HALT        = 2'b10,
    MODE_ACTIVE_HALT = 2'b11
  } npi_mode_e;

endpackage

// ---- logic/npi_ext_sense.sv ----
// Edge and level detector for one external interrupt group
`timescale 1ns/1ps
module npi_ext_sense #(
  parameter bit POL_ALLOWED = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] sens,
  input  wire logic       pol,
  input  wire logic       clr,
  output logic            req
);

  logic eff;
  logic prev_reg;
  logic latch_reg;
  logic rise;
  logic fall;
  logic hit;
  logic pinv;

  // Inversion turns fall into rise and fall+low into rise+high
  assign pinv = pol & POL_ALLOWED;
  assign eff  = pin ^ pinv;
  assign rise = eff & ~(prev_reg ^ pinv);
  assign fall = ~eff & (prev_reg ^ pinv);
  always_comb begin
    case (sens)
      2'h1:    hit = rise;
      2'h2:    hit = fall;
      2'h3:    hit = rise | fall;
      default: hit = fall;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= pin; // Raw pin, so a polarity write makes no false edge
    end
  end

  // Edge latch holds until entry or a sense register change; new edge wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= 1'b0;
    end else if (hit) begin
      latch_reg <= 1'b1;
    end else if (clr) begin
      latch_reg <= 1'b0;
    end
  end

  // Level part is live, not latched
  assign req = latch_reg | ((sens == npi_pkg::SENS_FALL_LOW) & ~eff);

endmodule

// ---- logic/npi_ctrl.sv ----
// Nested priority interrupt controller with AXI4-Lite registers
`timescale 1ns/1ps
module npi_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sources
  input  wire logic [13:0] periph_req,
  input  wire logic [3:0]  ext_pin,
  input  wire logic        spi_slave_mode,
  // CPU side
  input  wire logic [1:0]  cpu_mode,
  input  wire logic        irq_take,
  input  wire logic        enable_irq_instr,
  input  wire logic        disable_irq_instr,
  input  wire logic        halt_instr,
  input  wire logic        wait_for_irq_instr,
  input  wire logic        trap_instr,
  input  wire logic        cc_restore,
  input  wire logic [7:0]  cc_restore_val,
  output logic             irq_req,
  output logic [3:0]       irq_vec,
  output logic [15:0]      irq_addr,
  output logic             stack_push,
  output logic             wake,
  output logic             jump_if_masked,
  output logic             jump_if_unmasked,
  output logic [7:0]       cond_code_reg
);

  // ==========================================================
  // State
  logic [1:0]  prio_pair_reg [npi_pkg::NUM_VEC];
  logic [7:0]  ext_sense_ctrl_reg;
  logic [7:0]  cc_reg;
  logic        halt_exit_reg;
  logic        in_halt_reg;
  logic [3:0]  ext_req;
  logic [13:0] pend;
  logic [13:0] cand;
  logic        sel_valid;
  logic [3:0]  sel_vec;
  logic [1:0]  sel_lvl;
  logic [1:0]  cur_lvl;
  logic        ext_clr_all;
  logic [3:0]  ext_clr;
  logic        take_ok;

  // Level number from {hi, lo}: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] lvl_of(input logic [1:0] code);
    lvl_of = {~(code[1] ^ code[0]), code[0]};
  endfunction

  // ==========================================================
  // External groups
  npi_ext_sense #(.POL_ALLOWED(1'b1)) u_ext_a (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_pin[0]),
    .sens (ext_sense_ctrl_reg[npi_pkg::SENS_A_POS +: 2]),
    .pol  (ext_sense_ctrl_reg[npi_pkg::POL_A_POS]),
    .clr  (ext_clr[0]),
    .req  (ext_req[0])
  );
  npi_ext_sense #(.POL_ALLOWED(1'b0)) u_ext_f (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_pin[1]),
    .sens (ext_sense_ctrl_reg[npi_pkg::SENS_A_POS +: 2]),
    .pol  (ext_sense_ctrl_reg[npi_pkg::POL_A_POS]),
    .clr  (ext_clr[1]),
    .req  (ext_req[1])
  );
  npi_ext_sense #(.POL_ALLOWED(1'b1)) u_ext_b_low (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_pin[2]),
    .sens (ext_sense_ctrl_reg[npi_pkg::SENS_B_POS +: 2]),
    .pol  (ext_sense_ctrl_reg[npi_pkg::POL_B_POS]),
    .clr  (ext_clr[2]),
    .req  (ext_req[2])
  );
  npi_ext_sense #(.POL_ALLOWED(1'b0)) u_ext_b_high (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_pin[3]),
    .sens (ext_sense_ctrl_reg[npi_pkg::SENS_B_POS +: 2]),
    .pol  (ext_sense_ctrl_reg[npi_pkg::POL_B_POS]),
    .clr  (ext_clr[3]),
    .req  (ext_req[3])
  );

  // ==========================================================
  // Pending set and selection
  always_comb begin
    pend = periph_req;
    pend[0] = 1'b0;
    pend[6] = 1'b0;
    pend[npi_pkg::VEC_EXT_A +: 4] = ext_req;
  end

  assign cur_lvl = lvl_of({cc_reg[npi_pkg::CC_HI_POS], cc_reg[npi_pkg::CC_LO_POS]});

  // Halt filter stays until the first service after exit
  always_comb begin
    cand = pend;
    if (cpu_mode[1] | in_halt_reg | halt_exit_reg) begin
      cand = pend & npi_pkg::HALT_WAKE_MASK;
      cand[npi_pkg::VEC_SPI] = pend[npi_pkg::VEC_SPI] & spi_slave_mode;
      cand[npi_pkg::VEC_CLK] = pend[npi_pkg::VEC_CLK]
        & ((cpu_mode == npi_pkg::MODE_ACTIVE_HALT) | ~cpu_mode[1]);
    end
  end

  // Scan from lowest number; only strictly higher level replaces
  always_comb begin
    sel_valid = 1'b0;
    sel_vec   = 4'h0;
    sel_lvl   = 2'h0;
    for (int i = 0; i < npi_pkg::NUM_VEC; i++) begin
      if (cand[i] && lvl_of(prio_pair_reg[i]) > cur_lvl) begin
        if (!sel_valid || lvl_of(prio_pair_reg[i]) > sel_lvl) begin
          sel_valid = 1'b1;
          sel_vec   = i[3:0];
          sel_lvl   = lvl_of(prio_pair_reg[i]);
        end
      end
    end
  end

  assign take_ok = irq_take & irq_req & ~trap_instr;

  // ==========================================================
  // Request to the CPU
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req  <= 1'b0;
      irq_vec  <= 4'h0;
      irq_addr <= npi_pkg::VEC_ADDR_TOP;
    end else begin
      irq_req  <= sel_valid & ~take_ok;
      irq_vec  <= sel_vec;
      irq_addr <= npi_pkg::VEC_ADDR_TOP - {11'h000, sel_vec, 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_push <= 1'b0;
    end else begin
      stack_push <= take_ok | trap_instr;
    end
  end

  // ==========================================================
  // Low power tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_halt_reg   <= 1'b0;
      halt_exit_reg <= 1'b0;
      wake          <= 1'b0;
    end else begin
      in_halt_reg <= cpu_mode[1];
      if (in_halt_reg && !cpu_mode[1]) begin
        halt_exit_reg <= 1'b1;
      end else if (take_ok) begin
        halt_exit_reg <= 1'b0;
      end
      case (cpu_mode)
        npi_pkg::MODE_WAIT:        wake <= |pend;
        npi_pkg::MODE_HALT:        wake <= |cand;
        npi_pkg::MODE_ACTIVE_HALT: wake <= |cand;
        default:                   wake <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Condition code priority bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cc_reg <= npi_pkg::CC_RST;
    end else if (trap_instr) begin
      cc_reg[npi_pkg::CC_HI_POS] <= 1'b1;
      cc_reg[npi_pkg::CC_LO_POS] <= 1'b1;
    end else if (take_ok) begin
      cc_reg[npi_pkg::CC_HI_POS] <= prio_pair_reg[irq_vec][1];
      cc_reg[npi_pkg::CC_LO_POS] <= prio_pair_reg[irq_vec][0];
    end else if (cc_restore) begin
      cc_reg <= {2'h3, cc_restore_val[5:0]};
    end else if (disable_irq_instr) begin
      cc_reg[npi_pkg::CC_HI_POS] <= npi_pkg::CODE_LVL3[1];
      cc_reg[npi_pkg::CC_LO_POS] <= npi_pkg::CODE_LVL3[0];
    end else if (enable_irq_instr | halt_instr | wait_for_irq_instr) begin
      cc_reg[npi_pkg::CC_HI_POS] <= npi_pkg::CODE_LVL0[1];
      cc_reg[npi_pkg::CC_LO_POS] <= npi_pkg::CODE_LVL0[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_code_reg    <= npi_pkg::CC_RST;
      jump_if_masked   <= 1'b1;
      jump_if_unmasked <= 1'b0;
    end else begin
      cond_code_reg    <= cc_reg;
      jump_if_masked   <= (cur_lvl == 2'h3);
      jump_if_unmasked <= (cur_lvl != 2'h3);
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic        sense_wr;
  logic [7:0]  sense_new;
  logic [3:0]  wr_reg_idx;

  assign wr_fire    = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_reg_idx = aw_addr_reg[5:2];
  assign wr_hit     = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= npi_pkg::OFF_PENDING);
  assign sense_new  = w_data_reg[7:0] & npi_pkg::EXT_SENSE_MASK;
  assign sense_wr   = wr_fire & w_strb_reg[0] & (aw_addr_reg == npi_pkg::OFF_EXT_SENSE)
                      & (cur_lvl == 2'h3);
  assign ext_clr_all = sense_wr & (sense_new != ext_sense_ctrl_reg);
  always_comb begin
    ext_clr = {4{ext_clr_all}};
    if (take_ok && irq_vec >= 4'(npi_pkg::VEC_EXT_A)
        && irq_vec <= 4'(npi_pkg::VEC_EXT_B_HI)) begin
      ext_clr[2'(irq_vec - 4'(npi_pkg::VEC_EXT_A))] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= npi_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? npi_pkg::RESP_OKAY : npi_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Priority pairs; writing the level 0 code leaves a pair alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < npi_pkg::NUM_VEC; i++) begin
        prio_pair_reg[i] <= npi_pkg::SW_PRIO_RST[1:0];
      end
    end else if (wr_fire && wr_hit && w_strb_reg[0] && wr_reg_idx < 4'h4) begin
      for (int j = 0; j < 4; j++) begin
        if (w_data_reg[2*j +: 2] != npi_pkg::CODE_LVL0
            && (4 * wr_reg_idx + j) < npi_pkg::NUM_VEC) begin
          prio_pair_reg[4 * wr_reg_idx + j] <= w_data_reg[2*j +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sense_ctrl_reg <= npi_pkg::EXT_SENSE_RST;
    end else if (sense_wr) begin
      ext_sense_ctrl_reg <= sense_new;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic [3:0] rd_idx;

  assign rd_idx = s_axi_araddr[5:2];
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      npi_pkg::OFF_SW_PRIO_0, npi_pkg::OFF_SW_PRIO_1, npi_pkg::OFF_SW_PRIO_2: begin
        for (int j = 0; j < 4; j++) begin
          rd_byte[2*j +: 2] = prio_pair_reg[4 * rd_idx + j];
        end
      end
      npi_pkg::OFF_SW_PRIO_3: begin
        rd_byte = {npi_pkg::PRIO3_RO_BITS, prio_pair_reg[13], prio_pair_reg[12]};
      end
      npi_pkg::OFF_EXT_SENSE: rd_byte = ext_sense_ctrl_reg;
      npi_pkg::OFF_COND_CODE: rd_byte = cc_reg;
      npi_pkg::OFF_PENDING:   rd_byte = {2'h0, pend[13:8]};
      default:                rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= npi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= (s_axi_araddr == npi_pkg::OFF_PENDING)
                       ? {18'h00000, pend} : {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? npi_pkg::RESP_OKAY : npi_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ---- dv/npi_ctrl_asserts.sv ----
// Port-level assertion checker for the interrupt controller
`timescale 1ns/1ps
module npi_ctrl_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [1:0]  cpu_mode,
  input wire logic        irq_take,
  input wire logic        enable_irq_instr,
  input wire logic        disable_irq_instr,
  input wire logic        trap_instr,
  input wire logic        cc_restore,
  input wire logic        irq_req,
  input wire logic [3:0]  irq_vec,
  input wire logic [15:0] irq_addr,
  input wire logic        stack_push,
  input wire logic        wake,
  input wire logic        jump_if_masked,
  input wire logic        jump_if_unmasked,
  input wire logic [7:0]  cond_code_reg
);
  // ==========================================================
  // Current priority code {hi, lo} as seen on the port copy
  logic [1:0] cc_lvl;
  assign cc_lvl = {cond_code_reg[5], cond_code_reg[3]};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_take_push;
    irq_take && irq_req && !trap_instr |=> stack_push;
  endproperty
  a_take_push: assert property (p_take_push)
    else $error("no stack push after take");
  property p_push_cause;
    stack_push |-> $past(irq_take && irq_req) || $past(trap_instr);
  endproperty
  a_push_cause: assert property (p_push_cause)
    else $error("stack push without take or trap");
  property p_trap_level;
    trap_instr |=> ##1 cc_lvl == 2'h3;
  endproperty
  a_trap_level: assert property (p_trap_level)
    else $error("trap did not set level 3");
  property p_enable_level;
    enable_irq_instr && !trap_instr && !irq_take && !cc_restore && !disable_irq_instr
      |=> ##1 cc_lvl == 2'h2;
  endproperty
  a_enable_level: assert property (p_enable_level)
    else $error("enable did not load level 0");
  property p_disable_level;
    disable_irq_instr && !trap_instr && !irq_take && !cc_restore |=> ##1 cc_lvl == 2'h3;
  endproperty
  a_disable_level: assert property (p_disable_level)
    else $error("disable did not load level 3");
  property p_jump_flags;
    (jump_if_masked == (cc_lvl == 2'h3)) && (jump_if_unmasked != jump_if_masked);
  endproperty
  a_jump_flags: assert property (p_jump_flags)
    else $error("jump flags disagree with level");
  property p_masked_quiet;
    jump_if_masked && $past(jump_if_masked) |-> !irq_req;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("request offered at level 3");
  property p_vec_addr;
    irq_req |-> irq_addr == 16'hFFFA - {11'h000, irq_vec, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector address mismatch");
  property p_take_drop;
    irq_take && irq_req && !trap_instr |=> !irq_req;
  endproperty
  a_take_drop: assert property (p_take_drop)
    else $error("request not withdrawn after take");
  property p_wait_wake;
    cpu_mode == 2'h1 && irq_req |-> ##[0:2] wake;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("no wake from wait");
endmodule

bind npi_ctrl npi_ctrl_asserts npi_ctrl_asserts_inst (
  .clk(clk), .rst(rst), .cpu_mode(cpu_mode), .irq_take(irq_take),
  .enable_irq_instr(enable_irq_instr), .disable_irq_instr(disable_irq_instr),
  .trap_instr(trap_instr), .cc_restore(cc_restore), .irq_req(irq_req),
  .irq_vec(irq_vec), .irq_addr(irq_addr), .stack_push(stack_push), .wake(wake),
  .jump_if_masked(jump_if_masked), .jump_if_unmasked(jump_if_unmasked),
  .cond_code_reg(cond_code_reg)
);

// ---- dv/npi_cpu_model.sv ----
// Behavioural CPU core: takes offered vectors, stacks and restores flags
`timescale 1ns/1ps
module npi_cpu_model #(
  parameter int MAX_DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       auto_take,
  input  wire logic [3:0] take_dly,
  input  wire logic       ret_req,
  input  wire logic       irq_req,
  input  wire logic [7:0] cond_code_reg,
  output logic            irq_take,
  output logic            cc_restore,
  output logic [7:0]      cc_restore_val
);
  logic [7:0] stack_q [MAX_DEPTH];
  int         depth;
  logic [3:0] cnt;
  // ==========================================================
  // Take, push and return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_take <= 1'b0;
      cc_restore <= 1'b0;
      cc_restore_val <= 8'h00;
      cnt <= 4'h0;
      depth <= 0;
    end else begin
      irq_take <= 1'b0;
      cc_restore <= 1'b0;
      // Nesting capped here since overflow would go unnoticed
      if (auto_take && irq_req && !irq_take && depth < MAX_DEPTH) begin
        if (cnt >= take_dly) begin
          irq_take <= 1'b1;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
      if (irq_take && irq_req) begin
        stack_q[depth] <= cond_code_reg;
        depth <= depth + 1;
      end else if (ret_req && depth > 0) begin
        cc_restore <= 1'b1;
        cc_restore_val <= stack_q[depth-1];
        depth <= depth - 1;
      end
    end
  end
endmodule

// ---- dv/npi_ctrl_tb.sv ----
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
module npi_ctrl_tb;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, spi_slave_mode, irq_take, cc_restore;
  logic irq_req, stack_push, wake, jm, jnm, auto_take, ret_req;
  logic [7:0] awaddr, araddr, cc_val, cc;
  logic [31:0] wdata, rdata, r;
  logic [1:0] bresp, rresp, cpu_mode, resp;
  logic [13:0] periph_req;
  logic [3:0] ext_pin, irq_vec, take_dly;
  logic [4:0] instr;
  logic [15:0] irq_addr;
  int error_cnt, checked, cyc;

  npi_ctrl npi_ctrl_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_req(periph_req), .ext_pin(ext_pin),
    .spi_slave_mode(spi_slave_mode), .cpu_mode(cpu_mode), .irq_take(irq_take),
    .enable_irq_instr(instr[0]), .disable_irq_instr(instr[1]),
    .wait_for_irq_instr(instr[2]), .halt_instr(instr[3]), .trap_instr(instr[4]),
    .cc_restore(cc_restore), .cc_restore_val(cc_val), .irq_req(irq_req),
    .irq_vec(irq_vec), .irq_addr(irq_addr), .stack_push(stack_push), .wake(wake),
    .jump_if_masked(jm), .jump_if_unmasked(jnm), .cond_code_reg(cc));
  npi_cpu_model npi_cpu_model_inst (.clk(clk), .rst(rst), .auto_take(auto_take),
    .take_dly(take_dly), .ret_req(ret_req), .irq_req(irq_req), .cond_code_reg(cc),
    .irq_take(irq_take), .cc_restore(cc_restore), .cc_restore_val(cc_val));

  always #2.5 clk = ~clk;
  // Run is under 200 cycles; ceiling at 6000 leaves ample slack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, npi_pkg::RESP_OKAY}, "write resp");
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!(arvalid && arready));
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    instr <= 5'h01 << i;
    @(posedge clk);
    instr <= 5'h00;
  endtask
  task automatic ret();
    ret_req <= 1;
    @(posedge clk);
    ret_req <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic take();
    auto_take <= 1;
    do @(posedge clk); while (!stack_push);
    auto_take <= 0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_req();
    do @(posedge clk); while (!irq_req);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    clk = 0; rst = 1; cyc = 0; error_cnt = 0; checked = 0; awvalid = 0; wvalid = 0;
    bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    periph_req = 0; ext_pin = 4'hF; spi_slave_mode = 0; cpu_mode = 0; instr = 0;
    auto_take = 0; ret_req = 0; take_dly = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(npi_pkg::OFF_SW_PRIO_0 + 8'(i * 4), r);
      chk(r, 32'h000000FF, "prio reset");
    end
    rd(npi_pkg::OFF_EXT_SENSE, r);
    chk(r, 32'h00000000, "sense reset");
    rd(npi_pkg::OFF_COND_CODE, r);
    chk(r, 32'h000000EA, "cc reset");
    rd(8'h1C, r);
    chk({30'h0, resp}, {30'h0, npi_pkg::RESP_SLVERR}, "unmapped");
    wr(npi_pkg::OFF_SW_PRIO_3, 8'h00);
    rd(npi_pkg::OFF_SW_PRIO_3, r);
    chk(r, 32'h000000F0, "prio3 upper");
    wr(npi_pkg::OFF_SW_PRIO_0, 8'hCF);
    wr(npi_pkg::OFF_SW_PRIO_0, 8'h64);
    rd(npi_pkg::OFF_SW_PRIO_0, r);
    chk(r, 32'h00000044, "level0 write");
    $display("test registers finished");
    wr(npi_pkg::OFF_EXT_SENSE, 8'h10);
    ext_pin[0] <= 0;
    repeat (2) @(posedge clk);
    ext_pin[0] <= 1;
    rd(npi_pkg::OFF_PENDING, r);
    chk(r & 32'h4, 32'h4, "edge latched");
    wr(npi_pkg::OFF_EXT_SENSE, 8'h18);
    rd(npi_pkg::OFF_PENDING, r);
    chk(r & 32'h4, 32'h0, "sense change clear");
    wr(npi_pkg::OFF_EXT_SENSE, 8'h10);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      repeat (3) @(posedge clk);
      chk({cc[5], cc[3]}, (i == 1 || i == 4) ? 2'h3 : 2'h2, "instr level");
      chk(jm, i == 1 || i == 4, "masked jump");
      chk(jnm, !(i == 1 || i == 4), "unmasked jump");
    end
    pulse(0);
    wr(npi_pkg::OFF_EXT_SENSE, 8'h00);
    rd(npi_pkg::OFF_EXT_SENSE, r);
    chk(r, 32'h00000010, "sense locked");
    $display("test instructions finished");
    wr(npi_pkg::OFF_SW_PRIO_0, 8'hDF);
    wr(npi_pkg::OFF_SW_PRIO_2, 8'hF5);
    periph_req[9:8] <= 2'h3;
    wait_req();
    chk(irq_vec, 4'h8, "tie by vector");
    chk(irq_addr, 16'hFFEA, "vector address");
    take();
    chk({cc[5], cc[3]}, 2'h1, "entry level");
    repeat (4) @(posedge clk);
    chk(irq_req, 1'b0, "no equal preempt");
    periph_req[8] <= 0;
    wr(npi_pkg::OFF_SW_PRIO_2, 8'hF1);
    wait_req();
    chk(irq_vec, 4'h9, "nested preempt");
    take_dly <= 4'h3;
    take();
    chk({cc[5], cc[3]}, 2'h0, "nested level");
    periph_req[9] <= 0;
    ret();
    chk({cc[5], cc[3]}, 2'h1, "restore one");
    ret();
    chk({cc[5], cc[3]}, 2'h2, "restore main");
    $display("test nesting finished");
    wr(npi_pkg::OFF_SW_PRIO_2, 8'hF3);
    take_dly <= 4'h0;
    pulse(3);
    cpu_mode <= 2'h2;
    periph_req[8] <= 1;
    repeat (4) @(posedge clk);
    chk({wake, irq_req}, 2'h0, "halt filter");
    ext_pin[0] <= 0;
    @(posedge clk);
    ext_pin[0] <= 1;
    wait_req();
    repeat (2) @(posedge clk);
    chk(irq_vec, 4'h2, "halt first");
    chk(wake, 1'b1, "halt wake");
    rd(npi_pkg::OFF_PENDING, r);
    chk(r & 32'h4, 32'h4, "edge held");
    cpu_mode <= 2'h0;
    take();
    wait_req();
    chk(irq_vec, 4'h8, "deferred source");
    rd(npi_pkg::OFF_PENDING, r);
    chk(r & 32'h4, 32'h0, "edge cleared");
    cpu_mode <= 2'h1;
    repeat (3) @(posedge clk);
    chk(wake, 1'b1, "wait wake");
    cpu_mode <= 2'h3;
    periph_req[1] <= 1;
    repeat (3) @(posedge clk);
    chk({wake, irq_vec}, 5'h11, "active halt clock");
    cpu_mode <= 2'h2;
    repeat (3) @(posedge clk);
    chk({wake, irq_req}, 2'h0, "full halt clock");
    spi_slave_mode <= 1;
    periph_req[7] <= 1;
    repeat (3) @(posedge clk);
    chk({wake, irq_vec}, 5'h17, "slave spi wake");
    $display("test low power finished");
    end_of_test();
  end
endmodule
